// File: hdl/cfe_map.svh
// Purpose: register offsets, field positions, reset values and timing counts
// Assumes: byte offsets on a 32-bit Avalon-MM slave, one register per word
// Notes: definitions only
`ifndef CFE_MAP_SVH
`define CFE_MAP_SVH

// Register byte offsets
`define CFE_OFS_STATUS 8'h00
`define CFE_OFS_FILLA_LO 8'h04
`define CFE_OFS_FILLA_HI 8'h08
`define CFE_OFS_SYNDROME 8'h0C
`define CFE_OFS_ERRA_LO 8'h10
`define CFE_OFS_ERRA_HI 8'h14
`define CFE_OFS_DCSTAT 8'h18
`define CFE_OFS_TAG 8'h1C
`define CFE_OFS_CTRL 8'h20
`define CFE_OFS_CONFIG 8'h24

// Status field positions
`define CFE_ST_TAGADR 0
`define CFE_ST_TAGCTL 1
`define CFE_ST_HARD 2
`define CFE_ST_SOFT 3
`define CFE_ST_CMD_LSB 4
`define CFE_ST_FECC 8
`define CFE_ST_FPAR 9
`define CFE_ST_FIRD 10
`define CFE_ST_QW_LSB 11
`define CFE_ST_SEO 13

// Control and config field positions
`define CFE_CTRL_PARITY 0
`define CFE_CFG_WIDE 4
`define CFE_CFG_RATIO_LSB 8

// Reset-time strap positions on the interrupt request inputs
`define CFE_STRAP_WIDE 5
`define CFE_STRAP_DIV_MSB 2

// Reset values and widths
`define CFE_CTRL_RESET 1'b0
`define CFE_TAG_W 24
`define CFE_RATIO_MIN 4'h2
`define CFE_RATIO_MAX 4'h8

`endif

// File: hdl/cfe_pkg.sv
// Purpose: types shared by the fill error capture block
// Assumes: constants live in cfe_map.svh
// Notes: event carriers are one-cycle qualified by their valid bit (done for the probe)
`include "cfe_map.svh"

package cfe_pkg;

  typedef enum logic [1:0] {
    BUS_IDLE = 2'b01,
    BUS_ACK = 2'b10
  } cfe_bus_st_t;

  // One completed cache fill, erroneous or not
  typedef struct packed {
    logic valid;
    logic istream;
    logic eccErr;
    logic parErr;
    logic extCacheUsed;
    logic [33:5] blockAddr;
    logic [4:2] loadAddr;
    logic [1:0] badQuadword;
    logic [13:0] syndrome;
    logic parLowBad;
    logic parHighBad;
    logic [4:0] destinationRegister;
    logic longwordLoad;
    logic lockedLoad;
    logic integerLoad;
    logic legacyFloatFormat;
  } cfe_fill_t;

  // End of an external cache tag probe
  typedef struct packed {
    logic done;
    logic addrParErr;
    logic ctlParErr;
    logic [`CFE_TAG_W-1:0] result;
    logic [33:5] addr;
  } cfe_probe_t;

  // End of a system transaction
  typedef struct packed {
    logic valid;
    logic softErrorAcknowledge;
    logic hardErrorAcknowledge;
    logic [2:0] cycleRequestCode;
    logic [33:5] addr;
  } cfe_cycle_t;

endpackage

// File: hdl/cfe_capture.sv
// Purpose: capture and report cache fill, tag parity and system bus errors
// Assumes: events arrive synchronous to mclk; straps held one cycle past reset
// Notes: registers reached over Avalon-MM, one wait cycle on every access
//
// How it works
// (RQ1) Instruction fill error: write unchanged, validate, machine check
// (RQ2) Data fill error: write unchanged, validate, machine check
// (RQ3) ECC fill error sets flag, stream bit, overflow
// (RQ4) Capture block address and bad quadword index
// (RQ5) Data fills keep load address bits four..two
// (RQ6) ECC fill error captures failing quadword syndrome
// (RQ7) Parity mode syndrome marks bad longwords
// (RQ8) Parity fill errors only in parity mode
// (RQ9) Bus address and low status unpredictable after fill
// (RQ10) Data fill captures destination register and load type
// (RQ11) Tag register keeps probe result if cache used
// (RQ12) Tag address parity: miss, flag, address, check
// (RQ13) Tag control parity: force miss, flag, capture, check
// (RQ14) Soft acknowledge: corrected-read interrupt, flag, command, address
// (RQ15) Hard acknowledge: machine check, flag, command, address
// (RQ16) Bus width and clock ratio set at reset
// (RQ17) External logic straps bus width during reset
// (RQ18) External logic straps divisor code during reset
// (RQ19) System ignores address bit three when wide
// (RQ20) System returns three-bit read data acknowledge
// (RQ21) Captured state locked until software unlock access
//
// The Avalon-MM interface to the registers and the register addresses were decided locally.
`timescale 1ns/100ps
`default_nettype none
`include "cfe_map.svh"

module cfe_capture
  import cfe_pkg::*;
#(
  parameter int BLOCK_W = 256
) (
  // Clock and reset
  input wire logic mclk,
  input wire logic arst_n,
  // Avalon-MM slave
  input wire logic [7:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  // Reset-time configuration straps
  input wire logic [5:0] cfgStrap,
  // Fill, probe and transaction events
  input wire cfe_fill_t fillEvt,
  input wire logic [BLOCK_W-1:0] fillData,
  input wire cfe_probe_t probeEvt,
  input wire cfe_cycle_t cycleEvt,
  // Cache writes
  output logic icacheFillWrite,
  output logic dcacheFillWrite,
  output logic fillMarkValid,
  output logic [BLOCK_W-1:0] fillBlockOut,
  // Error signalling
  output logic machineCheck,
  output logic correctedReadInterrupt,
  output logic forceExternalMiss,
  // Interface configuration
  output logic busWide128,
  output logic [3:0] sysClockRatio
);

  // Refused at elaboration, not at run time:
  // the fill block moves in whole quadwords
  if (BLOCK_W < 64 || (BLOCK_W % 64) != 0) begin : gBadBlockW
    $error("BLOCK_W must be a nonzero multiple of 64");
  end

  typedef struct packed {
    cfe_bus_st_t busSt;
    logic waitReq;
    logic [31:0] rdata;
    logic cfgDone;
    logic wide;
    logic [3:0] ratio;
    logic parityMode;
    logic fillLock;
    logic fillEcc;
    logic fillPar;
    logic fillIrd;
    logic fillSeo;
    logic [1:0] qw;
    logic [33:2] fillAddr;
    logic [13:0] syn;
    logic busLock;
    logic tagAdrPar;
    logic tagCtlPar;
    logic softErr;
    logic hardErr;
    logic [2:0] cmd;
    logic [33:5] busAddr;
    logic [8:0] dcStat;
    logic tagLock;
    logic [`CFE_TAG_W-1:0] tag;
    logic mchk;
    logic corrected_read_interrupt;
    logic forceMiss;
    logic icWr;
    logic dcWr;
    logic markValid;
    logic [BLOCK_W-1:0] block;
  } cfe_state_t;

  cfe_state_t s_q;
  cfe_state_t s_d;

  // Reset release through two flops; only the second is used
  logic [1:0] rstSync_q;
  logic rst_n;

  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      rstSync_q <= 2'b00;
    end else begin
      rstSync_q <= {rstSync_q[0], 1'b1};
    end
  end

  assign rst_n = rstSync_q[1];

  // Divisor code to ratio: 0..6 give 2..8, 7 also gives 8
  function automatic logic [3:0] divRatio(input logic [2:0] code);
    logic [3:0] r;
    r = `CFE_RATIO_MIN + {1'b0, code};
    if (r > `CFE_RATIO_MAX) begin
      r = `CFE_RATIO_MAX;
    end
    return r;
  endfunction

  function automatic logic [31:0] statusWord(input cfe_state_t st);
    logic [31:0] w;
    w = 32'h0000_0000;
    w[`CFE_ST_TAGADR] = st.tagAdrPar;
    w[`CFE_ST_TAGCTL] = st.tagCtlPar;
    w[`CFE_ST_HARD] = st.hardErr;
    w[`CFE_ST_SOFT] = st.softErr;
    w[`CFE_ST_CMD_LSB +: 3] = st.cmd;
    w[`CFE_ST_FECC] = st.fillEcc;
    w[`CFE_ST_FPAR] = st.fillPar;
    w[`CFE_ST_FIRD] = st.fillIrd;
    w[`CFE_ST_QW_LSB +: 2] = st.qw;
    w[`CFE_ST_SEO] = st.fillSeo;
    return w;
  endfunction

  function automatic logic [31:0] regRead(input cfe_state_t st, input logic [7:0] a);
    logic [31:0] w;
    w = 32'h0000_0000;
    case (a)
      `CFE_OFS_STATUS: w = statusWord(st);
      `CFE_OFS_FILLA_LO: w = {st.fillAddr[31:2], 2'h0};
      `CFE_OFS_FILLA_HI: w = {30'h0000_0000, st.fillAddr[33:32]};
      `CFE_OFS_SYNDROME: w = {18'h0_0000, st.syn};
      `CFE_OFS_ERRA_LO: w = {st.busAddr[31:5], 5'h00};
      `CFE_OFS_ERRA_HI: w = {30'h0000_0000, st.busAddr[33:32]};
      `CFE_OFS_DCSTAT: w = {23'h00_0000, st.dcStat};
      `CFE_OFS_TAG: w = {{(32 - `CFE_TAG_W){1'b0}}, st.tag};
      `CFE_OFS_CTRL: w = {31'h0000_0000, st.parityMode};
      `CFE_OFS_CONFIG: begin
        w[`CFE_CFG_WIDE] = st.wide;
        w[`CFE_CFG_RATIO_LSB +: 4] = st.ratio;
      end
      default: w = 32'h0000_0000;
    endcase
    return w;
  endfunction

  logic accRd;
  logic accWr;
  logic fillErr;

  always_comb begin
    s_d = s_q;
    accRd = (s_q.busSt == BUS_ACK) && avs_read;
    accWr = (s_q.busSt == BUS_ACK) && avs_write;
    fillErr = fillEvt.valid && (s_q.parityMode ? fillEvt.parErr : fillEvt.eccErr); // RQ8

    // Slave: request seen in IDLE, answered one cycle later
    case (s_q.busSt)
      BUS_IDLE: begin
        s_d.waitReq = 1'b1;
        if (avs_read || avs_write) begin
          s_d.busSt = BUS_ACK;
          s_d.waitReq = 1'b0;
          s_d.rdata = regRead(s_q, avs_address);
        end
      end
      BUS_ACK: begin
        s_d.busSt = BUS_IDLE;
        s_d.waitReq = 1'b1;
      end
      default: begin
        s_d.busSt = BUS_IDLE;
        s_d.waitReq = 1'b1;
      end
    endcase

    // Pulses
    s_d.mchk = 1'b0;
    s_d.corrected_read_interrupt = 1'b0;
    s_d.forceMiss = 1'b0;
    s_d.icWr = 1'b0;
    s_d.dcWr = 1'b0;
    s_d.markValid = 1'b0;

    // Straps taken on the first edge after reset release
    if (!s_q.cfgDone) begin
      s_d.cfgDone = 1'b1;
      s_d.wide = cfgStrap[`CFE_STRAP_WIDE]; // RQ16
      s_d.ratio = divRatio(cfgStrap[`CFE_STRAP_DIV_MSB:0]); // RQ16
    end

    // Software writes and unlocks; events below run after so a set wins
    if (accWr && avs_address == `CFE_OFS_CTRL && avs_byteenable[0]) begin
      s_d.parityMode = avs_writedata[`CFE_CTRL_PARITY];
    end
    if (accWr && avs_address == `CFE_OFS_TAG) begin
      s_d.tagLock = 1'b0; // RQ21
    end
    if (accRd && avs_address == `CFE_OFS_FILLA_LO) begin
      s_d.fillLock = 1'b0; // RQ21
      s_d.fillEcc = 1'b0;
      s_d.fillPar = 1'b0;
      s_d.fillIrd = 1'b0;
      s_d.fillSeo = 1'b0;
    end
    if (accRd && avs_address == `CFE_OFS_STATUS) begin
      s_d.busLock = 1'b0; // RQ21
      s_d.tagAdrPar = 1'b0;
      s_d.tagCtlPar = 1'b0;
      s_d.softErr = 1'b0;
      s_d.hardErr = 1'b0;
    end

    // Every fill block goes to its cache as delivered and is validated
    if (fillEvt.valid) begin
      s_d.icWr = fillEvt.istream; // RQ1
      s_d.dcWr = !fillEvt.istream; // RQ2
      s_d.markValid = 1'b1;
      s_d.block = fillData;
    end

    // Tag register follows every probe until locked
    if (probeEvt.done && !s_d.tagLock) begin
      s_d.tag = probeEvt.result;
    end

    if (fillErr) begin
      s_d.mchk = 1'b1; // RQ1 RQ2
      if (s_d.fillLock) begin
        s_d.fillSeo = 1'b1; // RQ3
      end else begin
        s_d.fillLock = 1'b1; // RQ21
        s_d.fillEcc = !s_q.parityMode; // RQ3
        s_d.fillPar = s_q.parityMode; // RQ8
        s_d.fillIrd = fillEvt.istream; // RQ3 RQ8
        s_d.fillSeo = 1'b0;
        s_d.qw = fillEvt.badQuadword; // RQ4
        s_d.fillAddr[33:5] = fillEvt.blockAddr; // RQ4
        // Instruction fills leave the low bits meaningless; zero is kept
        s_d.fillAddr[4:2] = fillEvt.istream ? 3'h0 : fillEvt.loadAddr; // RQ5
        if (s_q.parityMode) begin
          s_d.syn = {6'h00, fillEvt.parHighBad, 6'h00, fillEvt.parLowBad}; // RQ7
        end else begin
          s_d.syn = fillEvt.syndrome; // RQ6
        end
        // Bus address and low status are left alone, software ignores them
        if (!fillEvt.istream) begin
          s_d.dcStat = {fillEvt.destinationRegister, fillEvt.longwordLoad,
                        fillEvt.lockedLoad, fillEvt.integerLoad,
                        fillEvt.legacyFloatFormat}; // RQ10 RQ9
        end
      end
      if (fillEvt.extCacheUsed) begin
        s_d.tagLock = 1'b1; // RQ11
      end
    end

    if (probeEvt.done && (probeEvt.addrParErr || probeEvt.ctlParErr)) begin
      s_d.mchk = 1'b1; // RQ12 RQ13
      s_d.forceMiss = 1'b1; // RQ12 RQ13
      s_d.tagLock = 1'b1; // RQ13
      if (probeEvt.addrParErr) begin
        s_d.tagAdrPar = 1'b1; // RQ12
      end
      if (probeEvt.ctlParErr) begin
        s_d.tagCtlPar = 1'b1; // RQ13
      end
      if (!s_d.busLock) begin
        s_d.busLock = 1'b1; // RQ21
        s_d.busAddr = probeEvt.addr; // RQ12 RQ13
      end
    end

    if (cycleEvt.valid && (cycleEvt.softErrorAcknowledge || cycleEvt.hardErrorAcknowledge)) begin
      if (cycleEvt.softErrorAcknowledge) begin
        s_d.corrected_read_interrupt = 1'b1; // RQ14
        s_d.softErr = 1'b1; // RQ14
      end
      if (cycleEvt.hardErrorAcknowledge) begin
        s_d.mchk = 1'b1; // RQ15
        s_d.hardErr = 1'b1; // RQ15
      end
      // A probe error in the same cycle keeps the address slot first
      if (!s_d.busLock) begin
        s_d.busLock = 1'b1; // RQ21
        s_d.cmd = cycleEvt.cycleRequestCode; // RQ14 RQ15
        s_d.busAddr = cycleEvt.addr; // RQ14 RQ15
      end
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      s_q <= '0;
      s_q.busSt <= BUS_IDLE;
      s_q.waitReq <= 1'b1;
      s_q.ratio <= `CFE_RATIO_MAX;
      s_q.parityMode <= `CFE_CTRL_RESET;
    end else begin
      s_q <= s_d;
    end
  end

  assign avs_readdata = s_q.rdata;
  assign avs_waitrequest = s_q.waitReq;
  assign icacheFillWrite = s_q.icWr;
  assign dcacheFillWrite = s_q.dcWr;
  assign fillMarkValid = s_q.markValid;
  assign fillBlockOut = s_q.block;
  assign machineCheck = s_q.mchk;
  assign correctedReadInterrupt = s_q.corrected_read_interrupt;
  assign forceExternalMiss = s_q.forceMiss;
  assign busWide128 = s_q.wide;
  assign sysClockRatio = s_q.ratio;

endmodule // cfe_capture

`default_nettype wire

// File: tb/cfe_sys_model.sv
// Purpose: system logic and cache RAM side that raises fill, probe and cycle events
// Assumes: the bench calls the send tasks right after a clock edge
// Notes: fill data turn over once a fill is done, so stale data never look valid
`timescale 1ns/100ps
`default_nettype none
module cfe_sys_model
  import cfe_pkg::*;
#(
  parameter logic [5:0] STRAP = 6'h25,
  parameter int BLOCK_W = 256
) (
  // Clock
  input wire logic mclk,
  // Events toward the block
  output cfe_fill_t fillEvt,
  output logic [BLOCK_W-1:0] fillData,
  output cfe_probe_t probeEvt,
  output cfe_cycle_t cycleEvt,
  // Straps, held from reset onward
  output logic [5:0] cfgStrap
);
  assign cfgStrap = STRAP;
  // Far-end pins the block has no port for; kept at their legal levels here
  logic [1:0] writeDataSelect;
  logic [2:0] readDataAcknowledge;
  assign writeDataSelect = 2'b00;
  initial begin
    fillEvt = '0;
    fillData = '0;
    probeEvt = '0;
    cycleEvt = '0;
    readDataAcknowledge = 3'h0;
  end
  task sendFill(input cfe_fill_t f, input logic [BLOCK_W-1:0] d);
    @(posedge mclk);
    fillEvt <= f;
    fillData <= d;
    readDataAcknowledge <= 3'h1;
    @(posedge mclk);
    fillEvt <= '0;
    fillData <= ~d;
    readDataAcknowledge <= 3'h0;
  endtask
  task sendProbe(input cfe_probe_t p);
    @(posedge mclk);
    probeEvt <= p;
    @(posedge mclk);
    probeEvt <= '0;
  endtask
  task sendCycle(input cfe_cycle_t c);
    @(posedge mclk);
    cycleEvt <= c;
    @(posedge mclk);
    cycleEvt <= '0;
  endtask
endmodule // cfe_sys_model
`default_nettype wire

// File: tb/cfe_capture_asserts.sv
// Purpose: port checks of the fill error capture block
// Assumes: parity or ECC mode is not visible at the ports
// Notes: bound to every cfe_capture instance
`timescale 1ns/100ps
`default_nettype none
module cfe_capture_asserts
  import cfe_pkg::*;
#(
  parameter int BLOCK_W = 256
) (
  // Clock and reset
  input wire logic mclk,
  input wire logic arst_n,
  // Bus
  input wire logic avs_read,
  input wire logic avs_waitrequest,
  // Events
  input wire cfe_fill_t fillEvt,
  input wire logic [BLOCK_W-1:0] fillData,
  input wire cfe_probe_t probeEvt,
  input wire cfe_cycle_t cycleEvt,
  // Outputs
  input wire logic icacheFillWrite,
  input wire logic dcacheFillWrite,
  input wire logic fillMarkValid,
  input wire logic [BLOCK_W-1:0] fillBlockOut,
  input wire logic machineCheck,
  input wire logic correctedReadInterrupt,
  input wire logic forceExternalMiss,
  input wire logic [3:0] sysClockRatio
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!arst_n);
  sequence s_ack;
    !avs_waitrequest ##1 avs_waitrequest;
  endsequence
  property p_bus_answer;
    $rose(avs_read) |-> ##[1:3] s_ack;
  endproperty
  a_bus_answer: assert property (p_bus_answer) else $error("read not answered");
  property p_ifill;
    fillEvt.valid && fillEvt.istream |=> icacheFillWrite && !dcacheFillWrite && fillMarkValid;
  endproperty
  a_ifill: assert property (p_ifill) else $error("ifetch fill not written");
  property p_dfill;
    fillEvt.valid && !fillEvt.istream |=> dcacheFillWrite && !icacheFillWrite && fillMarkValid;
  endproperty
  a_dfill: assert property (p_dfill) else $error("data fill not written");
  property p_fill_copy;
    fillEvt.valid |=> fillBlockOut == $past(fillData);
  endproperty
  a_fill_copy: assert property (p_fill_copy) else $error("fill block altered");
  property p_probe_err;
    probeEvt.done && (probeEvt.addrParErr || probeEvt.ctlParErr) |=> forceExternalMiss && machineCheck;
  endproperty
  a_probe_err: assert property (p_probe_err) else $error("tag parity not reported");
  property p_miss_cause;
    forceExternalMiss |-> $past(probeEvt.done && (probeEvt.addrParErr || probeEvt.ctlParErr));
  endproperty
  a_miss_cause: assert property (p_miss_cause) else $error("miss without cause");
  property p_soft;
    cycleEvt.valid && cycleEvt.softErrorAcknowledge |=> correctedReadInterrupt;
  endproperty
  a_soft: assert property (p_soft) else $error("soft error not signalled");
  property p_hard;
    cycleEvt.valid && cycleEvt.hardErrorAcknowledge |=> machineCheck;
  endproperty
  a_hard: assert property (p_hard) else $error("hard error not signalled");
  property p_ratio;
    sysClockRatio >= 4'h2 && sysClockRatio <= 4'h8;
  endproperty
  a_ratio: assert property (p_ratio) else $error("clock ratio out of range");
endmodule // cfe_capture_asserts
bind cfe_capture cfe_capture_asserts #(.BLOCK_W(BLOCK_W)) cfe_capture_asserts_inst (
  .mclk(mclk), .arst_n(arst_n), .avs_read(avs_read), .avs_waitrequest(avs_waitrequest),
  .fillEvt(fillEvt), .fillData(fillData), .probeEvt(probeEvt), .cycleEvt(cycleEvt),
  .icacheFillWrite(icacheFillWrite), .dcacheFillWrite(dcacheFillWrite),
  .fillMarkValid(fillMarkValid), .fillBlockOut(fillBlockOut), .machineCheck(machineCheck),
  .correctedReadInterrupt(correctedReadInterrupt), .forceExternalMiss(forceExternalMiss),
  .sysClockRatio(sysClockRatio));
`default_nettype wire

// File: tb/cfe_capture_tb.sv
// Purpose: self-checking bench of the fill error capture block
// Assumes: ECC mode after reset; straps come from the system model
// Notes: every register access waits on waitrequest, never on a fixed count
`timescale 1ns/100ps
`default_nettype none
`include "cfe_map.svh"
module cfe_capture_tb;
  import cfe_pkg::*;
  localparam int BLOCK_W = 256;
  logic mclk = 1'b0;
  logic arst_n = 1'b0;
  logic [7:0] avs_address = 8'h00;
  logic avs_read = 1'b0;
  logic avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h0;
  logic [31:0] avs_readdata;
  logic avs_waitrequest;
  logic [5:0] cfgStrap;
  cfe_fill_t fillEvt;
  logic [BLOCK_W-1:0] fillData;
  logic [BLOCK_W-1:0] fillBlockOut;
  cfe_probe_t probeEvt;
  cfe_cycle_t cycleEvt;
  logic icacheFillWrite, dcacheFillWrite, fillMarkValid, machineCheck;
  logic correctedReadInterrupt, forceExternalMiss, busWide128;
  logic [3:0] sysClockRatio;
  int miscompares = 0;
  int total_checks = 0;
  int cycles = 0;
  logic [33:0] ea;
  initial begin
    forever #50 mclk = ~mclk;
  end
  cfe_capture #(.BLOCK_W(BLOCK_W)) cfe_capture_inst (
    .mclk(mclk), .arst_n(arst_n), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(4'hF),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .cfgStrap(cfgStrap),
    .fillEvt(fillEvt), .fillData(fillData), .probeEvt(probeEvt), .cycleEvt(cycleEvt),
    .icacheFillWrite(icacheFillWrite), .dcacheFillWrite(dcacheFillWrite),
    .fillMarkValid(fillMarkValid), .fillBlockOut(fillBlockOut), .machineCheck(machineCheck),
    .correctedReadInterrupt(correctedReadInterrupt), .forceExternalMiss(forceExternalMiss),
    .busWide128(busWide128), .sysClockRatio(sysClockRatio));
  cfe_sys_model #(.STRAP(6'h25), .BLOCK_W(BLOCK_W)) cfe_sys_model_inst (
    .mclk(mclk), .fillEvt(fillEvt), .fillData(fillData), .probeEvt(probeEvt),
    .cycleEvt(cycleEvt), .cfgStrap(cfgStrap));
  task print_verdict;
    $display("checks %0d mismatches %0d", total_checks, miscompares);
    if (miscompares == 0 && total_checks > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  always @(posedge mclk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      miscompares = miscompares + 1;
      print_verdict;
    end
  end
  task chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task acc(input logic wr, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
    @(posedge mclk);
    avs_address <= a;
    avs_read <= ~wr;
    avs_write <= wr;
    avs_writedata <= d;
    @(posedge mclk);
    while (avs_waitrequest !== 1'b0) begin
      @(posedge mclk);
    end
    q = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
  endtask
  task rd(input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] q;
    acc(1'b0, a, 32'h0, q);
    chk(q, exp);
  endtask
  task wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    acc(1'b1, a, d, q);
  endtask
  initial begin
    repeat (20) @(posedge mclk);
    arst_n <= 1'b1;
    repeat (5) @(posedge mclk);
    chk(32'({busWide128, sysClockRatio}), 32'h17);
    rd(`CFE_OFS_CONFIG, 32'h710);
    rd(8'h40, 32'h0);
    // A clean probe loads the tag value that the fill error then freezes
    cfe_sys_model_inst.sendProbe('{done:1'b1, result:24'hABCDEF, default:'0});
    cfe_sys_model_inst.sendFill('{valid:1'b1, eccErr:1'b1, extCacheUsed:1'b1,
      blockAddr:29'h1091A2B3, loadAddr:3'h5, badQuadword:2'h2, syndrome:14'h1ABC,
      destinationRegister:5'h0A, longwordLoad:1'b1, integerLoad:1'b1, default:'0},
      {8{32'hC0DE0001}});
    @(posedge mclk);
    chk(32'({icacheFillWrite, dcacheFillWrite, fillMarkValid, machineCheck}), 32'h7);
    chk(fillBlockOut[31:0], 32'hC0DE0001);
    cfe_sys_model_inst.sendFill('{valid:1'b1, eccErr:1'b1, default:'0}, '0);
    cfe_sys_model_inst.sendProbe('{done:1'b1, result:24'h123456, default:'0});
    rd(`CFE_OFS_STATUS, 32'h3100);
    rd(`CFE_OFS_SYNDROME, 32'h1ABC);
    rd(`CFE_OFS_DCSTAT, 32'hAA);
    rd(`CFE_OFS_TAG, 32'hABCDEF);
    rd(`CFE_OFS_FILLA_HI, 32'h2);
    rd(`CFE_OFS_FILLA_LO, 32'h12345674);
    wr(`CFE_OFS_TAG, 32'h0);
    wr(`CFE_OFS_CTRL, 32'h1);
    cfe_sys_model_inst.sendFill('{valid:1'b1, istream:1'b1, parErr:1'b1, parLowBad:1'b1,
      parHighBad:1'b1, blockAddr:29'h0800007C, badQuadword:2'h1, default:'0},
      {8{32'h5A5A0F0F}});
    @(posedge mclk);
    chk(32'({icacheFillWrite, dcacheFillWrite, fillMarkValid, machineCheck}), 32'hB);
    rd(`CFE_OFS_STATUS, 32'hE00);
    rd(`CFE_OFS_SYNDROME, 32'h81);
    rd(`CFE_OFS_FILLA_HI, 32'h1);
    rd(`CFE_OFS_FILLA_LO, 32'hF80);
    // Two probe faults, then every command code, odd codes with soft and even codes with hard endings
    for (int k = 0; k < 10; k++) begin
      ea = {2'h3, 27'(k + 64), 5'h0};
      if (k < 2) begin
        cfe_sys_model_inst.sendProbe('{done:1'b1, addrParErr:(k == 0), ctlParErr:(k == 1),
          addr:ea[33:5], default:'0});
      end else begin
        cfe_sys_model_inst.sendCycle('{valid:1'b1, softErrorAcknowledge:k[0],
          hardErrorAcknowledge:!k[0], cycleRequestCode:3'(k - 2), addr:ea[33:5]});
      end
      @(posedge mclk);
      chk(32'({machineCheck, correctedReadInterrupt, forceExternalMiss}),
        k < 2 ? 32'h5 : (k[0] ? 32'h2 : 32'h4));
      rd(`CFE_OFS_ERRA_LO, ea[31:0]);
      // The bad quadword index of the last fill stays; unlock clears only the flags
      rd(`CFE_OFS_STATUS,
        32'h800 | (k < 2 ? 32'(1 << k) : 32'({3'(k - 2), k[0], !k[0], 2'b00})));
    end
    rd(`CFE_OFS_ERRA_HI, 32'h3);
    // A later error must not replace the held address
    cfe_sys_model_inst.sendProbe('{done:1'b1, ctlParErr:1'b1, addr:29'h100, default:'0});
    cfe_sys_model_inst.sendCycle('{valid:1'b1, hardErrorAcknowledge:1'b1, addr:29'h3,
      default:'0});
    rd(`CFE_OFS_ERRA_LO, 32'h2000);
    print_verdict;
  end
endmodule // cfe_capture_tb
`default_nettype wire
